// [design/ess_cmd_top.sv]
// normal-mode command interpreter behind the encoder serial port
// Operation
// - customer write stores wake threshold bits 15:9, gain bits 8:6
// - threshold resets to 4, never below 4, at most 127
// - cosine and sine array writes carry exclude/invert pair per element
// - array reads return stored pairs, all starting at zero
// - test write with bit 10 set triggers a digital reset
// - config write bit 15 enters sleep, cleared returns to normal
// - lock flag reads low in angle and turn reads while asleep
// - bit 11 enables hysteresis, default on: two equal results to change
// - hysteresis/reset write with bit 13 clears the turn counter
// - customer read returns threshold, gain, zeros and parity at bit 0
// - combined read returns turns in 15:8, angle in 7:0, no parity
// - store command latches angle when core supply ok; returns supply flags, angle (reference angle if not), parity
// - turn read returns lock, gain-loop level, turns and parity
// - angle read returns lock, gain-loop level, angle and parity
// - lock high only when converter locked; parity makes word even
// - controller drives select and clock; data line shared both ways
// - each frame is 5 command bits then 16 data bits, msb first
`timescale 1ns/1ps
`include "ess_defs.svh"
module ess_cmd_top (
  input  wire logic       clock_in,
  input  wire logic       srst_in,
  input  wire logic       ce_in,
  input  wire logic       chip_select_in,
  input  wire logic       serial_clock_in,
  input  wire logic       serial_data_line_in,
  output logic            serial_data_line_out,
  output logic            serial_data_line_oe_out,
  input  wire logic [7:0] angle_in,
  input  wire logic       angle_valid_in,
  input  wire logic [5:0] agc_in,
  input  wire logic       lock_in,
  input  wire logic       turn_up_in,
  input  wire logic       turn_down_in,
  input  wire logic       core_supply_ok_in,
  input  wire logic       supply_ok_in,
  output logic [6:0]      wake_threshold_out,
  output logic [2:0]      gain_out,
  output ess_pkg::ess_word_t cosine_array_out,
  output ess_pkg::ess_word_t sine_array_out,
  output logic            sleep_request_out,
  output logic            extra_hysteresis_enable_out,
  output logic            otp_reload_out,
  output logic            digital_reset_out,
  output logic [7:0]      angle_out,
  output logic [7:0]      turn_count_out,
  output logic [7:0]      ref_angle_out
);
  import ess_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // parity helper
  function automatic ess_word_t even_par(input ess_word_t w);
    even_par = {w[15:1], ^w[15:1]};
  endfunction : even_par

  ////////////////////////////////////////////////////////////////////////
  // shifter
  ess_link_if link ();

  ess_shifter u_shifter (
    .clock_in                (clock_in),
    .srst_in                 (srst_in),
    .ce_in                   (ce_in),
    .chip_select_in          (chip_select_in),
    .serial_clock_in         (serial_clock_in),
    .serial_data_line_in     (serial_data_line_in),
    .serial_data_line_out    (serial_data_line_out),
    .serial_data_line_oe_out (serial_data_line_oe_out),
    .link                    (link.shifter)
  );

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [6:0] thr_reg;
  logic [2:0] gain_reg;
  ess_word_t  cos_reg, sin_reg;
  logic       sleep_reg, hyst_reg, otp_reg, grst_reg;
  logic [7:0] last_reg, ang_reg, turns_reg, ref_reg;
  logic [7:0] turns_next;

  ////////////////////////////////////////////////////////////////////////
  // write decode
  wire        wr_go     = link.wr_valid;
  ess_word_t  wd;
  ess_cmd_t   code;
  assign wd   = link.wr_data;
  assign code = link.cmd_code;
  wire        wr_cust   = wr_go && (code == `ESS_CMD_CUST_WR);
  wire        wr_cos    = wr_go && (code == `ESS_CMD_COS_WR);
  wire        wr_test   = wr_go && (code == `ESS_CMD_TEST_WR);
  wire        wr_hyst   = wr_go && (code == `ESS_CMD_HYST_WR);
  wire        wr_sin    = wr_go && (code == `ESS_CMD_SIN_WR);
  wire        wr_cfg    = wr_go && (code == `ESS_CMD_CFG_WR);
  wire        do_store  = link.cmd_valid &&
                          (code == `ESS_CMD_STORE_RD) && core_supply_ok_in;
  wire        cfg_rst   = srst_in | grst_reg;
  // floor keeps the wake comparator from firing on noise
  wire [6:0]  thr_clamp = (wd[15:9] < `ESS_THR_MIN) ? `ESS_THR_MIN
                                                     : wd[15:9];
  wire        clr_turns = wr_hyst && wd[`ESS_MULTI_BIT];
  wire [7:0]  turns_base = clr_turns ? 8'h00 : turns_reg;
  wire        lock_eff  = lock_in & ~sleep_reg;
  wire        hyst_take = !hyst_reg || (angle_in == last_reg);

  ////////////////////////////////////////////////////////////////////////
  // response words
  ess_word_t angle_word, turn_word, cust_word, store_word, both_word;
  ess_word_t rsp_word;
  wire [7:0] store_ang = core_supply_ok_in ? ang_reg : ref_reg;
  assign angle_word = even_par({lock_eff, agc_in, ang_reg,
                                1'h0});
  assign turn_word  = even_par({lock_eff, agc_in, turns_reg,
                                1'h0});
  assign cust_word  = even_par({thr_reg, gain_reg, 6'h00});
  assign store_word = even_par({core_supply_ok_in, supply_ok_in,
                                core_supply_ok_in, 4'h0, store_ang,
                                1'h0});
  assign both_word  = {turns_reg, ang_reg};
  // unlisted read codes return zeros
  assign rsp_word =
    (code == `ESS_CMD_ANGLE_RD) ? angle_word :
    (code == `ESS_CMD_TURN_RD)  ? turn_word  :
    (code == `ESS_CMD_SIN_RD)   ? sin_reg    :
    (code == `ESS_CMD_STORE_RD) ? store_word :
    (code == `ESS_CMD_BOTH_RD)  ? both_word  :
    (code == `ESS_CMD_COS_RD)   ? cos_reg    :
    (code == `ESS_CMD_CUST_RD)  ? cust_word  : 16'h0000;
  assign link.rsp_word = rsp_word;
  assign turns_next = turns_base + {7'h00, turn_up_in}
                                 - {7'h00, turn_down_in};

  assign wake_threshold_out          = thr_reg;
  assign gain_out                    = gain_reg;
  assign cosine_array_out            = cos_reg;
  assign sine_array_out              = sin_reg;
  assign sleep_request_out           = sleep_reg;
  assign extra_hysteresis_enable_out = hyst_reg;
  assign otp_reload_out              = otp_reg;
  assign digital_reset_out           = grst_reg;
  assign angle_out                   = ang_reg;
  assign turn_count_out              = turns_reg;
  assign ref_angle_out               = ref_reg;

  ////////////////////////////////////////////////////////////////////////
  // one-cycle command pulses
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      grst_reg <= 1'h0;
      otp_reg  <= 1'h0;
    end else if (ce_in) begin
      grst_reg <= wr_test && wd[`ESS_GENRST_BIT];
      // controller must send this after start-up and wake
      otp_reg  <= wr_hyst && wd[`ESS_OTP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration, cleared by either reset
  always_ff @(posedge clock_in) begin
    if (cfg_rst) begin
      thr_reg   <= `ESS_THR_RST;
      gain_reg  <= `ESS_GAIN_RST;
      cos_reg   <= `ESS_ARRAY_RST;
      sin_reg   <= `ESS_ARRAY_RST;
      sleep_reg <= `ESS_SLEEP_RST;
      hyst_reg  <= `ESS_HYSTERESIS_AND_RESETS;
    end else if (ce_in) begin
      if (wr_cust) begin
        thr_reg  <= thr_clamp;
        gain_reg <= wd[8:6];
      end
      if (wr_cos) begin
        cos_reg <= wd;
      end
      if (wr_sin) begin
        sin_reg <= wd;
      end
      if (wr_cfg) begin
        sleep_reg <= wd[`ESS_SLEEP_BIT];
      end
      if (wr_hyst) begin
        hyst_reg <= wd[`ESS_HYST_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // measurement path
  always_ff @(posedge clock_in) begin
    if (cfg_rst) begin
      last_reg  <= 8'h00;
      ang_reg   <= 8'h00;
      turns_reg <= 8'h00;
      ref_reg   <= 8'h00;
    end else if (ce_in) begin
      // a clear and a turn step in one cycle keep the step
      turns_reg <= turns_next;
      if (angle_valid_in) begin
        last_reg <= angle_in;
        if (hyst_take) begin
          ang_reg <= angle_in;
        end
      end
      if (do_store) begin
        ref_reg <= ang_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);

  AST_THR_FLOOR: assert property (
    thr_reg >= `ESS_THR_MIN
  ) else $error("wake threshold below floor");

  AST_CUST_WRITE: assert property (
    ce_in && wr_cust && !grst_reg |=>
      thr_reg == $past(thr_clamp) && gain_reg == $past(wd[8:6])
  ) else $error("customer settings not stored");

  AST_ARRAY_WRITE: assert property (
    ce_in && wr_cos && !grst_reg |=> cosine_array_out == $past(wd)
  ) else $error("cosine array not stored");

  AST_ARRAY_READ: assert property (
    code == `ESS_CMD_SIN_RD |-> rsp_word == sin_reg
  ) else $error("sine array readback wrong");

  AST_SLEEP_SET: assert property (
    ce_in && wr_cfg && !grst_reg |=>
      sleep_request_out == $past(wd[`ESS_SLEEP_BIT])
  ) else $error("sleep state not updated");

  AST_SLEEP_LOCK: assert property (
    sleep_reg && (code == `ESS_CMD_ANGLE_RD ||
                  code == `ESS_CMD_TURN_RD) |-> !rsp_word[15]
  ) else $error("lock reported during sleep");

  AST_PARITY: assert property (
    code != `ESS_CMD_BOTH_RD && (code == `ESS_CMD_ANGLE_RD ||
      code == `ESS_CMD_TURN_RD || code == `ESS_CMD_CUST_RD ||
      code == `ESS_CMD_STORE_RD) |-> ^rsp_word == 1'h0
  ) else $error("response parity odd");

  AST_BOTH_WORD: assert property (
    code == `ESS_CMD_BOTH_RD |-> rsp_word == {turns_reg, ang_reg}
  ) else $error("combined read layout wrong");

  AST_TURN_CLEAR: assert property (
    ce_in && clr_turns && !grst_reg && !turn_up_in && !turn_down_in
      |=> turn_count_out == 8'h00
  ) else $error("turn counter not cleared");

  AST_GEN_RESET: assert property (
    ce_in && wr_test && wd[`ESS_GENRST_BIT] |=> digital_reset_out
      ##1 (thr_reg == `ESS_THR_RST && cos_reg == `ESS_ARRAY_RST)
  ) else $error("digital reset not applied");

  AST_HYST_HOLD: assert property (
    ce_in && !grst_reg && hyst_reg && angle_valid_in &&
      angle_in != last_reg |=> $stable(angle_out)
  ) else $error("angle changed on single result");

  AST_STORE_REF: assert property (
    ce_in && do_store && !grst_reg |=> ref_reg == $past(ang_reg)
  ) else $error("reference angle not latched");

  AST_RESERVED: assert property (
    ce_in && !grst_reg && wr_go && code == 5'h14 |=>
      $stable(thr_reg) && $stable(cos_reg) && $stable(sleep_reg)
  ) else $error("reserved code changed state");

  AST_CUST_READ: assert property (
    code == `ESS_CMD_CUST_RD |->
      rsp_word[15:1] == {thr_reg, gain_reg, 5'h00}
  ) else $error("customer readback layout wrong");

  AST_STORE_FLAGS: assert property (
    code == `ESS_CMD_STORE_RD |-> rsp_word[15:13] ==
      {core_supply_ok_in, supply_ok_in, core_supply_ok_in}
  ) else $error("store flags misplaced");

  AST_ANGLE_WORD: assert property (
    code == `ESS_CMD_ANGLE_RD |-> rsp_word[14:1] == {agc_in, ang_reg}
  ) else $error("angle read layout wrong");

  AST_HYST_OFF: assert property (
    ce_in && !grst_reg && !hyst_reg && angle_valid_in |=>
      angle_out == $past(angle_in)
  ) else $error("angle not taken with hysteresis off");

  COV_CUST_WRITE: cover property (ce_in && wr_cust);
  COV_ANGLE_READ: cover property (
    link.cmd_valid && code == `ESS_CMD_ANGLE_RD);
  COV_SLEEP: cover property (ce_in && wr_cfg && wd[`ESS_SLEEP_BIT]);
  COV_HYST_HOLD: cover property (
    hyst_reg && angle_valid_in && angle_in != last_reg);
endmodule : ess_cmd_top

// [design/ess_shifter.sv]
// pin synchroniser and bit shifter for the serial frame
`timescale 1ns/1ps
`include "ess_defs.svh"
module ess_shifter (
  input  wire logic   clock_in,
  input  wire logic   srst_in,
  input  wire logic   ce_in,
  input  wire logic   chip_select_in,
  input  wire logic   serial_clock_in,
  input  wire logic   serial_data_line_in,
  output logic        serial_data_line_out,
  output logic        serial_data_line_oe_out,
  ess_link_if.shifter link
);
  import ess_pkg::*;
  logic       cs_s1_reg, cs_s2_reg;
  logic       ck_s1_reg, ck_s2_reg, ck_s3_reg;
  logic       d_s1_reg, d_s2_reg;
  ess_state_e state_reg;
  logic [4:0] cnt_reg;
  ess_word_t  in_reg, out_reg, wdata_reg;
  ess_cmd_t   code_reg;
  logic       is_read_reg, cmd_valid_reg, wr_valid_reg, sdo_reg, oe_reg;
  wire        rise    = ck_s2_reg & ~ck_s3_reg;
  wire        fall    = ~ck_s2_reg & ck_s3_reg;
  wire [15:0] next_in = {in_reg[14:0], d_s2_reg};
  wire [4:0]  cnt_inc = cnt_reg + 5'h01;
  wire        last_cmd  = rise && (cnt_reg == `ESS_CMD_LAST);
  wire        last_data = rise && (cnt_reg == `ESS_DATA_LAST);

  assign link.cmd_valid          = cmd_valid_reg;
  assign link.cmd_code           = code_reg;
  assign link.wr_valid           = wr_valid_reg;
  assign link.wr_data            = wdata_reg;
  assign serial_data_line_out    = sdo_reg;
  assign serial_data_line_oe_out = oe_reg;

  ////////////////////////////////////////////////////////////////////////
  // pins come from the controller's domain: two flops first
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      {cs_s1_reg, cs_s2_reg, d_s1_reg, d_s2_reg} <= 4'h0;
      {ck_s1_reg, ck_s2_reg, ck_s3_reg}          <= 3'h0;
    end else if (ce_in) begin
      {cs_s1_reg, cs_s2_reg} <= {chip_select_in, cs_s1_reg};
      {d_s1_reg, d_s2_reg}   <= {serial_data_line_in, d_s1_reg};
      {ck_s1_reg, ck_s2_reg, ck_s3_reg} <=
        {serial_clock_in, ck_s1_reg, ck_s2_reg};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame: 5 command bits then 16 data bits, msb first
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state_reg     <= ESS_IDLE;
      cnt_reg       <= 5'h00;
      in_reg        <= 16'h0000;
      out_reg       <= 16'h0000;
      wdata_reg     <= 16'h0000;
      code_reg      <= 5'h00;
      is_read_reg   <= 1'h0;
      cmd_valid_reg <= 1'h0;
      wr_valid_reg  <= 1'h0;
      sdo_reg       <= 1'h0;
      oe_reg        <= 1'h0;
    end else if (ce_in) begin
      cmd_valid_reg <= 1'h0;
      wr_valid_reg  <= 1'h0;
      if (!cs_s2_reg) begin
        // bus floats the cycle after the synchronised select reads low
        state_reg <= ESS_IDLE;
        cnt_reg   <= 5'h00;
        oe_reg    <= 1'h0;
      end else begin
        unique case (state_reg)
          ESS_IDLE: begin
            state_reg <= ESS_CMD;
            cnt_reg   <= 5'h00;
          end
          ESS_CMD: begin
            if (rise) begin
              in_reg  <= next_in;
              cnt_reg <= cnt_inc;
            end
            if (last_cmd) begin
              code_reg      <= next_in[4:0];
              cmd_valid_reg <= 1'h1;
              // msb clear selects a read
              is_read_reg   <= ~next_in[`ESS_DIR_BIT];
              state_reg     <= ESS_DATA;
              cnt_reg       <= 5'h00;
            end
          end
          ESS_DATA: begin
            if (cmd_valid_reg && is_read_reg) begin
              out_reg <= link.rsp_word;
            end
            // device drives on falling edges during reads
            if (fall && is_read_reg) begin
              sdo_reg <= out_reg[15];
              out_reg <= {out_reg[14:0], 1'h0};
              oe_reg  <= 1'h1;
            end
            if (rise) begin
              in_reg  <= next_in;
              cnt_reg <= cnt_inc;
            end
            if (last_data) begin
              state_reg    <= ESS_DONE;
              wr_valid_reg <= ~is_read_reg;
              wdata_reg    <= next_in;
            end
          end
          ESS_DONE: begin
            state_reg <= ESS_DONE;
          end
        endcase
      end
    end
  end
endmodule : ess_shifter

// [dv/ess_ctl_model.sv]
// serial controller model for the encoder command port
`timescale 1ns/1ps
module ess_ctl_model (
  input  wire logic clock_in,
  input  wire logic dev_data_in,
  input  wire logic dev_oe_in,
  output logic      chip_select_out,
  output logic      serial_clock_out,
  output logic      line_out
);
  logic m_oe  = 1'b0;
  logic m_dat = 1'b0;
  logic last  = 1'b0;
  // no pull on the line: a released line toggles, never a stale bit
  assign line_out = dev_oe_in ? dev_data_in
                  : (m_oe ? m_dat : ~last);
  initial begin
    chip_select_out  = 1'b0;
    serial_clock_out = 1'b0;
  end
  always @(posedge clock_in) begin
    last <= line_out;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clock_in);
  endtask : wt
  // 80 ns link clock, idle low between frames
  task automatic xfer(input logic [4:0] c, input logic [15:0] d,
                      output logic [15:0] r);
    logic [20:0] b;
    b = {c, d};
    r = 16'h0000;
    @(posedge clock_in);
    chip_select_out <= 1'b1;
    wt(3);
    for (int i = 20; i >= 0; i--) begin
      m_oe  <= (i > 15) || c[4];
      m_dat <= b[i];
      wt(4);
      serial_clock_out <= 1'b1;
      wt(1);
      if (i < 16) r[i] = line_out;
      wt(3);
      serial_clock_out <= 1'b0;
    end
    wt(4);
    chip_select_out <= 1'b0;
    m_oe <= 1'b0;
    wt(6);
  endtask : xfer
endmodule : ess_ctl_model

// [dv/testbench.sv]
// self-checking bench for the normal-mode command interpreter
`timescale 1ns/1ps
`include "ess_defs.svh"
module testbench;
  import ess_pkg::*;
  logic       clock_in = 1'b0;
  logic       srst_in  = 1'b1;
  logic       cs, sck, line, d_out, d_oe;
  logic [7:0] angle_in = 8'h00;
  logic       a_vld = 1'b0;
  logic       up    = 1'b0;
  logic       dn    = 1'b0;
  logic       lock  = 1'b1;
  logic       ce    = 1'b1;
  logic       sup   = 1'b1;
  logic [6:0] thr;
  logic [2:0] gain;
  ess_word_t  cos_w, sin_w, r;
  logic       slp, hyst, otp, drst;
  logic [7:0] ang, turns, refa;
  int         otp_n = 0;
  int         drst_n = 0;
  int         mismatches = 0;
  int         cmp_count = 0;
  initial begin
    forever #5 clock_in = ~clock_in;
  end
  ess_cmd_top dut_u (.clock_in(clock_in), .srst_in(srst_in), .ce_in(ce),
    .chip_select_in(cs), .serial_clock_in(sck),
    .serial_data_line_in(line), .serial_data_line_out(d_out),
    .serial_data_line_oe_out(d_oe), .angle_in(angle_in),
    .angle_valid_in(a_vld), .agc_in(6'h2A), .lock_in(lock),
    .turn_up_in(up), .turn_down_in(dn), .core_supply_ok_in(1'b1),
    .supply_ok_in(sup), .wake_threshold_out(thr), .gain_out(gain),
    .cosine_array_out(cos_w), .sine_array_out(sin_w),
    .sleep_request_out(slp), .extra_hysteresis_enable_out(hyst),
    .otp_reload_out(otp), .digital_reset_out(drst), .angle_out(ang),
    .turn_count_out(turns), .ref_angle_out(refa));
  ess_ctl_model ctl_u (.clock_in(clock_in), .dev_data_in(d_out),
    .dev_oe_in(d_oe), .chip_select_out(cs), .serial_clock_out(sck),
    .line_out(line));
  // counting pulses also proves they last a single cycle
  always @(posedge clock_in) begin
    if (otp === 1'b1) otp_n <= otp_n + 1;
    if (drst === 1'b1) drst_n <= drst_n + 1;
  end
  //////////////////////////////////////////////////////////////////////
  function automatic ess_word_t par(input ess_word_t w);
    return {w[15:1], ^w[15:1]};
  endfunction : par
  task automatic chk(input string n, input ess_word_t e, input ess_word_t g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input ess_cmd_t c, input ess_word_t d);
    ess_word_t x;
    ctl_u.xfer(c, d, x);
  endtask : wr
  task automatic rd(input ess_cmd_t c);
    ctl_u.xfer(c, 16'h0000, r);
  endtask : rd
  // k: 0 new angle result, 1 turn up, 2 turn down
  task automatic pulse(input int k, input logic [7:0] a);
    @(posedge clock_in);
    angle_in <= a;
    a_vld <= (k == 0);
    up <= (k == 1);
    dn <= (k == 2);
    @(posedge clock_in);
    {a_vld, up, dn} <= 3'b000;
    repeat (2) @(posedge clock_in);
  endtask : pulse
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (20000) @(posedge clock_in);
    mismatches++;
    finish_test();
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clock_in);
    srst_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    chk("thr", 16'h0004, {9'h000, thr});
    chk("cos", 16'h0000, cos_w);
    chk("sin", 16'h0000, sin_w);
    chk("hyst", 16'h0001, {15'h0000, hyst});
    rd(`ESS_CMD_CUST_RD);
    chk("cust", par(16'h0800), r);
    wr(`ESS_CMD_HYST_WR, 16'hA800);
    chk("otp", 16'h0001, 16'(otp_n));
    wr(`ESS_CMD_CUST_WR, 16'hFFFF);
    chk("thr", 16'h007F, {9'h000, thr});
    chk("gain", 16'h0007, {13'h0000, gain});
    wr(`ESS_CMD_CUST_WR, 16'h05FF);
    chk("thr", 16'h0004, {9'h000, thr});
    rd(`ESS_CMD_CUST_RD);
    chk("cust", par(16'h09C0), r);
    wr(`ESS_CMD_COS_WR, 16'hA5C3);
    wr(`ESS_CMD_SIN_WR, 16'h3C5A);
    chk("cos", 16'hA5C3, cos_w);
    chk("sin", 16'h3C5A, sin_w);
    rd(`ESS_CMD_COS_RD);
    chk("cos_rd", 16'hA5C3, r);
    rd(`ESS_CMD_SIN_RD);
    chk("sin_rd", 16'h3C5A, r);
    pulse(0, 8'h20);
    chk("ang", 16'h0000, {8'h00, ang});
    pulse(0, 8'h20);
    chk("ang", 16'h0020, {8'h00, ang});
    wr(`ESS_CMD_HYST_WR, 16'h0000);
    pulse(0, 8'h31);
    chk("ang", 16'h0031, {8'h00, ang});
    wr(`ESS_CMD_HYST_WR, 16'h0800);
    pulse(0, 8'h40);
    chk("ang", 16'h0031, {8'h00, ang});
    for (int i = 0; i < 3; i++) pulse(1, 8'h40);
    pulse(2, 8'h40);
    chk("turns", 16'h0002, {8'h00, turns});
    rd(`ESS_CMD_TURN_RD);
    chk("turn_rd", par({1'b1, 6'h2A, 8'h02, 1'b0}), r);
    rd(`ESS_CMD_ANGLE_RD);
    chk("ang_rd", par({1'b1, 6'h2A, 8'h31, 1'b0}), r);
    rd(`ESS_CMD_BOTH_RD);
    chk("both_rd", 16'h0231, r);
    @(posedge clock_in) lock <= 1'b0;
    rd(`ESS_CMD_ANGLE_RD);
    chk("ang_rd", par({1'b0, 6'h2A, 8'h31, 1'b0}), r);
    @(posedge clock_in) lock <= 1'b1;
    wr(`ESS_CMD_CFG_WR, 16'h8000);
    chk("sleep", 16'h0001, {15'h0000, slp});
    rd(`ESS_CMD_ANGLE_RD);
    chk("ang_rd", par({1'b0, 6'h2A, 8'h31, 1'b0}), r);
    rd(`ESS_CMD_TURN_RD);
    chk("turn_rd", par({1'b0, 6'h2A, 8'h02, 1'b0}), r);
    wr(`ESS_CMD_CFG_WR, 16'h0000);
    chk("sleep", 16'h0000, {15'h0000, slp});
    rd(`ESS_CMD_STORE_RD);
    chk("store", par({3'h7, 4'h0, 8'h31, 1'b0}), r);
    chk("ref", 16'h0031, {8'h00, refa});
    // a failing supply must clear bit 14 alone
    @(posedge clock_in) sup <= 1'b0;
    rd(`ESS_CMD_STORE_RD);
    chk("store", par({3'h5, 4'h0, 8'h31, 1'b0}), r);
    @(posedge clock_in) sup <= 1'b1;
    wr(`ESS_CMD_HYST_WR, 16'h2800);
    chk("turns", 16'h0000, {8'h00, turns});
    // reserved writes must leave threshold, cosine array and sleep alone; an unused read must return zeros
    wr(5'h14, 16'hFFFF);
    wr(5'h10, 16'hFFFF);
    chk("thr", 16'h0004, {9'h000, thr});
    chk("cos", 16'hA5C3, cos_w);
    chk("sleep", 16'h0000, {15'h0000, slp});
    rd(5'h05);
    chk("unk_rd", 16'h0000, r);
    pulse(1, 8'h40);
    // a low clock enable must freeze the turn count
    @(posedge clock_in) ce <= 1'b0;
    pulse(1, 8'h40);
    ce <= 1'b1;
    chk("turns", 16'h0001, {8'h00, turns});
    wr(`ESS_CMD_TEST_WR, 16'hFBFF);
    chk("drst", 16'h0000, 16'(drst_n));
    wr(`ESS_CMD_TEST_WR, 16'h0400);
    chk("drst", 16'h0001, 16'(drst_n));
    chk("turns", 16'h0000, {8'h00, turns});
    chk("gain", 16'h0000, {13'h0000, gain});
    finish_test();
  end
endmodule : testbench

// [include/ess_defs.svh]
// constants for the serial command interpreter of the angle encoder
`ifndef ESS_DEFS_SVH
`define ESS_DEFS_SVH
`define ESS_CMD_CUST_WR   5'h17
`define ESS_CMD_COS_WR    5'h16
`define ESS_CMD_TEST_WR   5'h15
`define ESS_CMD_HYST_WR   5'h13
`define ESS_CMD_SIN_WR    5'h12
`define ESS_CMD_CFG_WR    5'h11
`define ESS_CMD_CUST_RD   5'h07
`define ESS_CMD_COS_RD    5'h06
`define ESS_CMD_BOTH_RD   5'h04
`define ESS_CMD_STORE_RD  5'h03
`define ESS_CMD_SIN_RD    5'h02
`define ESS_CMD_TURN_RD   5'h01
`define ESS_CMD_ANGLE_RD  5'h00
`define ESS_DIR_BIT       4
`define ESS_CMD_LAST      5'h04
`define ESS_DATA_LAST     5'h0F
`define ESS_GENRST_BIT    10
`define ESS_SLEEP_BIT     15
`define ESS_OTP_BIT       15
`define ESS_MULTI_BIT     13
`define ESS_HYST_BIT      11
`define ESS_THR_RST       7'h04
`define ESS_THR_MIN       7'h04
`define ESS_GAIN_RST      3'h0
`define ESS_ARRAY_RST     16'h0000
`define ESS_HYSTERESIS_AND_RESETS      1'h1
`define ESS_SLEEP_RST     1'h0
`endif

// [include/ess_link_if.sv]
// link between the serial shifter and the command core
`timescale 1ns/1ps
interface ess_link_if;
  import ess_pkg::*;
  logic      cmd_valid;
  ess_cmd_t  cmd_code;
  ess_word_t rsp_word;
  logic      wr_valid;
  ess_word_t wr_data;
  modport shifter (output cmd_valid, cmd_code, wr_valid, wr_data,
                   input  rsp_word);
  modport core    (input  cmd_valid, cmd_code, wr_valid, wr_data,
                   output rsp_word);
endinterface : ess_link_if

// [include/ess_pkg.sv]
// types shared by the serial command interpreter modules
package ess_pkg;
  typedef enum logic [1:0] {
    ESS_IDLE = 2'b00,
    ESS_CMD  = 2'b01,
    ESS_DATA = 2'b10,
    ESS_DONE = 2'b11
  } ess_state_e;
  typedef logic [4:0]  ess_cmd_t;
  typedef logic [15:0] ess_word_t;
endpackage : ess_pkg
